/* chan_proc_pkg.sv */
package chan_proc_pkg;
	// Datapath: signed fixed point, value times 10^4
	localparam int DATA_W = 32;
	localparam int FRAC_DIGITS = 4;
	localparam int PREC_W = 3;
	localparam logic [PREC_W-1:0] PREC_MAX = 3'h4;
	localparam int SCALE = 10000;
	localparam int K_FRAC_BITS = 16;
	localparam int HOLD_W = 16;
	localparam int TC_W = 16;

	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SAMPLE_PERIOD_NS = 100000000;
	localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Time split of the default pattern ww:dd:hh:mm:ss
	localparam int SEC_PER_MIN = 60;
	localparam int MIN_PER_HOUR = 60;
	localparam int HOUR_PER_DAY = 24;
	localparam int DAY_PER_WEEK = 7;
	localparam int SEC_PER_HOUR = 3600;
	localparam int SEC_PER_DAY = 86400;
	localparam int SEC_PER_WEEK = 604800;

	// Reset values
	localparam logic signed [DATA_W-1:0] DATA_RST = 32'sh0000_0000;
	localparam logic [HOLD_W-1:0] HOLD_RST = 16'h0000;

	typedef enum logic [1:0] {FILT_OFF, FILT_SMOOTH, FILT_PEAK} filter_mode_t;
	typedef enum logic {DIR_PEAKS, DIR_VALLEYS} peak_dir_t;
	typedef enum logic [1:0] {RND_OFF, RND_STD, RND_FLOOR, RND_CEIL} round_mode_t;

	typedef struct packed {
		filter_mode_t mode;
		logic [TC_W-1:0] decay_const;
		logic [K_FRAC_BITS-1:0] decay_k;
	} filter_cfg_t;

	typedef struct packed {
		peak_dir_t dir;
		logic [DATA_W-1:0] threshold;
		logic [HOLD_W-1:0] hold_samples;
		logic rst_en;
	} peak_cfg_t;

	typedef struct packed {
		round_mode_t mode;
		logic [PREC_W-1:0] precision;
	} round_cfg_t;

	typedef struct packed {
		logic negative;
		logic [15:0] weeks;
		logic [2:0] days;
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic [13:0] frac;
	} time_split_t;
endpackage

/* chan_stream_partner.sv */
`timescale 1ns/10ps
module chan_stream_partner (
	// Clock
	input wire logic i_ref_clk,
	// Upstream source
	output logic o_valid,
	output logic signed [31:0] o_data,
	input wire logic i_ready,
	// Downstream sink
	input wire logic i_valid,
	input wire logic signed [31:0] i_value,
	input wire logic i_stall,
	output logic o_ready
);
	logic signed [31:0] got[$];
	initial begin
		o_valid = 1'b0;
		o_data = 32'sh0;
	end
	assign o_ready = !i_stall;
	always @(posedge i_ref_clk) begin
		if (i_valid && o_ready)
			got.push_back(i_value);
	end
	// Leading edge keeps back-to-back offers from toggling valid in one step
	task automatic send(input logic signed [31:0] x, input int lim, output logic ok);
		ok = 1'b0;
		@(posedge i_ref_clk);
		#1;
		o_valid = 1'b1;
		o_data = x;
		for (int n = 0; n < lim && !ok; n++) begin
			@(posedge i_ref_clk);
			ok = i_ready;
		end
		#1;
		o_valid = 1'b0;
		// Stale word must not look like live data
		o_data = ~x;
	endtask
endmodule // chan_stream_partner

/* channel_smooth_peak_round.sv */
`timescale 1ns/10ps
module channel_smooth_peak_round #(
	parameter int unsigned SAMPLE_CYCLES = chan_proc_pkg::SAMPLE_CYCLES,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Incoming samples
	input wire logic i_in_valid,
	input wire logic signed [chan_proc_pkg::DATA_W-1:0] i_in_data,
	output logic o_in_ready,
	// Configuration
	input wire chan_proc_pkg::filter_cfg_t i_filt_cfg,
	input wire chan_proc_pkg::peak_cfg_t i_peak_cfg,
	input wire chan_proc_pkg::round_cfg_t i_rnd_cfg,
	input wire logic signed [chan_proc_pkg::DATA_W-1:0] i_peak_rst_src,
	// Processed samples
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic signed [chan_proc_pkg::DATA_W-1:0] o_value,
	output logic signed [chan_proc_pkg::DATA_W-1:0] o_disp_value,
	output logic o_bin_on,
	output chan_proc_pkg::time_split_t o_time,
	output logic o_peak_held,
	output logic o_strobe
);
	localparam int CNT_W = $clog2(SAMPLE_CYCLES + 1);
	localparam int W = chan_proc_pkg::DATA_W;

	// Sample strobe
	// Free-running, so sample spacing never depends on data arrival
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	always_comb begin
		tick_d = 1'b0;
		cnt_d = cnt_q + 1'b1;
		if (cnt_q >= CNT_W'(SAMPLE_CYCLES - 1)) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	// Input buffer: absorbs bursts between strobes
	logic in_ready_q;
	logic f_valid, f_ready, f_in_ready;
	logic [W-1:0] f_data;
	logic signed [W-1:0] x;

	// Level mirrored below so ready stays a plain flop
	sample_fifo #(
		.WIDTH(W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_valid(i_in_valid && in_ready_q),
		.i_data(i_in_data),
		.o_ready(f_in_ready),
		.o_valid(f_valid),
		.o_data(f_data),
		.i_ready(f_ready)
	);
	assign x = f_data;

	// One sample consumed per strobe, only if the output slot is free
	assign f_ready = tick_q && f_valid && (!o_out_valid || i_out_ready);

	// Buffer level, counted here instead of peeking into the buffer
	localparam int OCC_W = $clog2(FIFO_DEPTH + 1);
	logic [OCC_W-1:0] occ_q, occ_d;
	logic take, give;

	// Take and give in one cycle leave the level unchanged
	always_comb begin
		take = i_in_valid && in_ready_q && f_in_ready;
		give = f_ready;
		occ_d = occ_q;
		if (take && !give) begin
			occ_d = occ_q + 1'b1;
		end else if (give && !take) begin
			occ_d = occ_q - 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			occ_q <= '0;
		end else begin
			occ_q <= occ_d;
		end
	end

	// Smoothing filter
	logic signed [W-1:0] ys_q, ys_d, y;
	logic hist_q, hist_d;
	logic signed [W:0] diff;
	logic signed [W+chan_proc_pkg::K_FRAC_BITS+1:0] prod;

	// k arrives as a Q16 fraction; the decay constant is only tested for zero
	always_comb begin
		diff = 33'(ys_q) - 33'(x);
		prod = diff * $signed({1'b0, i_filt_cfg.decay_k});
		y = x;
		if (i_filt_cfg.mode == chan_proc_pkg::FILT_SMOOTH && i_filt_cfg.decay_const != '0 && hist_q) begin
			// x + (y_prev - x) * k equals x(1-k) + y_prev k
			y = x + W'(prod >>> chan_proc_pkg::K_FRAC_BITS);
		end
		ys_d = ys_q;
		hist_d = hist_q;
		// History starts with the first sample, which passes straight through
		if (f_ready) begin
			ys_d = y;
			hist_d = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ys_q <= chan_proc_pkg::DATA_RST;
			hist_q <= 1'b0;
		end else begin
			ys_q <= ys_d;
			hist_q <= hist_d;
		end
	end

	// Peak / valley detector, worked in a sign-flipped domain for valleys
	logic signed [W-1:0] ext_q, ext_d, held_val_q, held_val_d, s, pk_s, pk;
	logic [chan_proc_pkg::HOLD_W-1:0] hold_q, hold_d;
	// seen_q: the signal has risen since the last peak or i_rst; an accepted reset source sets it at once
	logic held_q, held_d, seen_q, seen_d;
	logic valley, ext_rst, new_peak;
	logic signed [W:0] drop;

	always_comb begin
		valley = (i_peak_cfg.dir == chan_proc_pkg::DIR_VALLEYS);
		s = valley ? -y : y;
		drop = 33'(ext_q) - 33'(s);
		ext_rst = i_peak_cfg.rst_en && (i_peak_rst_src > 0);
		new_peak = seen_q && !ext_rst && (drop >= $signed({1'b0, i_peak_cfg.threshold}));
		ext_d = ext_q;
		held_val_d = held_val_q;
		hold_d = hold_q;
		held_d = held_q;
		seen_d = seen_q;
		if (f_ready && i_filt_cfg.mode == chan_proc_pkg::FILT_PEAK) begin
			// Reset source is looked at only on ticks
			if (ext_rst) begin
				held_d = 1'b0;
				hold_d = '0;
				ext_d = s;
				seen_d = 1'b1;
			end else if (!seen_q) begin
				// Follow the fall after a peak; arm again once the signal turns up
				ext_d = s;
				seen_d = (s > ext_q);
			end else if (s > ext_q) begin
				ext_d = s;
			end
			// Timer counts ticks; the last held tick clears the flag
			if (held_q && !ext_rst) begin
				hold_d = hold_q - 1'b1;
				held_d = (hold_q > 16'h0001);
			end
			// Recognised peak: latch the extreme, restart the timer, wait for a turn
			if (new_peak) begin
				held_val_d = ext_q;
				hold_d = i_peak_cfg.hold_samples;
				held_d = (i_peak_cfg.hold_samples != '0);
				ext_d = s;
				seen_d = 1'b0;
			end
		end
		pk_s = held_d ? held_val_d : s;
		pk = valley ? -pk_s : pk_s;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ext_q <= chan_proc_pkg::DATA_RST;
			held_val_q <= chan_proc_pkg::DATA_RST;
			hold_q <= chan_proc_pkg::HOLD_RST;
			held_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			ext_q <= ext_d;
			held_val_q <= held_val_d;
			hold_q <= hold_d;
			held_q <= held_d;
			seen_q <= seen_d;
		end
	end

	// Rounding and presentation
	logic signed [W-1:0] stage, rnd_val, rnd_disp;
	chan_proc_pkg::time_split_t tsplit;
	logic [W:0] mag;
	logic [W-1:0] secs;

	// Peak mode shows the detector; other modes the filter output
	assign stage = (i_filt_cfg.mode == chan_proc_pkg::FILT_PEAK) ? pk : y;

	// Rounded value feeds the binary and time views as well
	value_rounder u_round (
		.i_value(stage),
		.i_cfg(i_rnd_cfg),
		.o_value(rnd_val),
		.o_disp(rnd_disp)
	);

	always_comb begin
		// Units follow the fixed pattern ww:dd:hh:mm:ss
		// Seconds integer part with the fraction kept as ten-thousandths
		tsplit.negative = (rnd_val < 0);
		mag = tsplit.negative ? 33'(-33'(rnd_val)) : 33'(rnd_val);
		secs = W'(mag / 33'(chan_proc_pkg::SCALE));
		tsplit.frac = 14'(mag % 33'(chan_proc_pkg::SCALE));
		tsplit.seconds = 6'(secs % W'(chan_proc_pkg::SEC_PER_MIN));
		tsplit.minutes = 6'((secs / W'(chan_proc_pkg::SEC_PER_MIN)) % W'(chan_proc_pkg::MIN_PER_HOUR));
		tsplit.hours = 5'((secs / W'(chan_proc_pkg::SEC_PER_HOUR)) % W'(chan_proc_pkg::HOUR_PER_DAY));
		tsplit.days = 3'((secs / W'(chan_proc_pkg::SEC_PER_DAY)) % W'(chan_proc_pkg::DAY_PER_WEEK));
		tsplit.weeks = 16'(secs / W'(chan_proc_pkg::SEC_PER_WEEK));
	end

	// Output registers
	logic out_valid_d, peak_held_d, bin_on_d, in_ready_d, strobe_d;
	logic signed [W-1:0] value_d, disp_d;
	chan_proc_pkg::time_split_t time_d;

	// Stall: the output word and its flags hold until the sink takes it
	always_comb begin
		out_valid_d = o_out_valid && !i_out_ready;
		strobe_d = tick_q;
		// Ready only while a word still fits after this edge
		in_ready_d = (occ_d != OCC_W'(FIFO_DEPTH));
		value_d = o_value;
		disp_d = o_disp_value;
		bin_on_d = o_bin_on;
		time_d = o_time;
		peak_held_d = o_peak_held;
		if (f_ready) begin
			out_valid_d = 1'b1;
			value_d = rnd_val;
			disp_d = rnd_disp;
			bin_on_d = (rnd_val > 0);
			time_d = tsplit;
			peak_held_d = held_d && (i_filt_cfg.mode == chan_proc_pkg::FILT_PEAK);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_out_valid <= 1'b0;
			o_value <= chan_proc_pkg::DATA_RST;
			o_disp_value <= chan_proc_pkg::DATA_RST;
			o_bin_on <= 1'b0;
			o_time <= '0;
			o_peak_held <= 1'b0;
			o_strobe <= 1'b0;
			in_ready_q <= 1'b0;
		end else begin
			o_out_valid <= out_valid_d;
			o_value <= value_d;
			o_disp_value <= disp_d;
			o_bin_on <= bin_on_d;
			o_time <= time_d;
			o_peak_held <= peak_held_d;
			o_strobe <= strobe_d;
			in_ready_q <= in_ready_d;
		end
	end
	assign o_in_ready = in_ready_q;
endmodule // channel_smooth_peak_round

/* channel_smooth_peak_round_asserts.sv */
`timescale 1ns/10ps
module channel_smooth_peak_round_chk #(
	parameter int unsigned SAMPLE_CYCLES = 8
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Configuration and handshake
	input wire chan_proc_pkg::filter_cfg_t i_filt_cfg,
	input wire chan_proc_pkg::round_cfg_t i_rnd_cfg,
	input wire logic i_out_ready,
	// Outputs watched
	input wire logic o_in_ready,
	input wire logic o_out_valid,
	input wire logic signed [chan_proc_pkg::DATA_W-1:0] o_value,
	input wire logic signed [chan_proc_pkg::DATA_W-1:0] o_disp_value,
	input wire logic o_bin_on,
	input wire chan_proc_pkg::time_split_t o_time,
	input wire logic o_peak_held,
	input wire logic o_strobe
);
	int div;
	logic [31:0] gap_q, gap_d;
	// A strobe carries a fresh sample only if the output slot was free at the tick
	logic free_q, free_d;
	chan_proc_pkg::round_cfg_t cfg_q, cfg_d;
	// Config as seen at the tick, since the bench may change it right after
	always_comb begin
		cfg_d = i_rnd_cfg;
		free_d = !o_out_valid || i_out_ready;
		gap_d = o_strobe ? 32'h1 : gap_q + 32'h1;
		if (i_rst)
			gap_d = 32'hffff;
		case (cfg_q.precision)
			3'h0: div = 32'h2710;
			3'h1: div = 32'h3e8;
			3'h2: div = 32'h64;
			3'h3: div = 32'ha;
			default: div = 32'h1;
		endcase
	end
	always_ff @(posedge i_ref_clk) begin
		gap_q <= gap_d;
		cfg_q <= cfg_d;
		free_q <= free_d;
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	property p_bin;
		o_bin_on == (o_value > 32'sh0);
	endproperty
	a_bin: assert property (p_bin) else $error("binary state disagrees with value");
	property p_time;
		o_time.negative == (o_value < 32'sh0) && o_time.seconds < 6'h3c && o_time.minutes < 6'h3c
			&& o_time.hours < 5'h18 && o_time.days < 3'h7;
	endproperty
	a_time: assert property (p_time) else $error("time split out of range");
	property p_tick;
		o_strobe |-> gap_q >= SAMPLE_CYCLES;
	endproperty
	a_tick: assert property (p_tick) else $error("samples closer than one period");
	property p_still;
		!o_strobe && !$past(i_rst) |-> $stable(o_value) && $stable(o_peak_held);
	endproperty
	a_still: assert property (p_still) else $error("output moved without a sample");
	property p_stall;
		o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_value);
	endproperty
	a_stall: assert property (p_stall) else $error("stalled output dropped");
	property p_rst;
		disable iff (1'b0) i_rst |=> !o_out_valid && !o_in_ready && !o_strobe && o_value == 32'sh0 && !o_peak_held;
	endproperty
	a_rst: assert property (p_rst) else $error("state not cleared by reset");
	property p_round;
		o_strobe && o_out_valid && free_q && cfg_q.mode != chan_proc_pkg::RND_OFF |-> o_value % div == 0;
	endproperty
	a_round: assert property (p_round) else $error("value finer than precision");
	property p_cut;
		o_strobe && o_out_valid && free_q && cfg_q.mode == chan_proc_pkg::RND_OFF |-> o_disp_value % div == 0
			&& o_disp_value <= o_value && o_value - o_disp_value < div;
	endproperty
	a_cut: assert property (p_cut) else $error("display cut wrong");
	property p_held;
		o_peak_held |-> i_filt_cfg.mode == chan_proc_pkg::FILT_PEAK;
	endproperty
	a_held: assert property (p_held) else $error("peak held outside peak mode");
	c_held: cover property ($rose(o_peak_held));
	c_stall: cover property (o_out_valid && !i_out_ready);
	c_std: cover property (o_strobe && cfg_q.mode == chan_proc_pkg::RND_STD);
endmodule // channel_smooth_peak_round_chk
bind channel_smooth_peak_round channel_smooth_peak_round_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_filt_cfg(i_filt_cfg), .i_rnd_cfg(i_rnd_cfg),
	.i_out_ready(i_out_ready), .o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .o_value(o_value),
	.o_disp_value(o_disp_value), .o_bin_on(o_bin_on), .o_time(o_time), .o_peak_held(o_peak_held),
	.o_strobe(o_strobe));

/* channel_smooth_peak_round_bench.sv */
`timescale 1ns/10ps
module channel_smooth_peak_round_bench;
	localparam int SC = 8;
	logic clk, rst, stall, in_v, in_rdy, out_v, out_rdy, bin_on, held, strobe, ok;
	logic signed [31:0] in_d, val, disp, rst_src, e;
	logic signed [31:0] vals[3] = '{32'sh8707, -32'sh61a8, 32'sh0};
	chan_proc_pkg::filter_cfg_t filt;
	chan_proc_pkg::peak_cfg_t pk;
	chan_proc_pkg::round_cfg_t rnd;
	chan_proc_pkg::time_split_t tm;
	int err_total, checked, cyc, n;
	channel_smooth_peak_round #(.SAMPLE_CYCLES(SC), .FIFO_DEPTH(8)) DUT (
		.i_ref_clk(clk), .i_rst(rst), .i_in_valid(in_v), .i_in_data(in_d), .o_in_ready(in_rdy),
		.i_filt_cfg(filt), .i_peak_cfg(pk), .i_rnd_cfg(rnd), .i_peak_rst_src(rst_src),
		.o_out_valid(out_v), .i_out_ready(out_rdy), .o_value(val), .o_disp_value(disp),
		.o_bin_on(bin_on), .o_time(tm), .o_peak_held(held), .o_strobe(strobe));
	chan_stream_partner src (.i_ref_clk(clk), .o_valid(in_v), .o_data(in_d), .i_ready(in_rdy),
		.i_valid(out_v), .i_value(val), .i_stall(stall), .o_ready(out_rdy));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic report_and_stop();
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 32'h4e20) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
		checked++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Floor-based reference; standard rounds halves toward plus infinity
	function automatic logic signed [31:0] ref_rnd(input logic signed [31:0] v, input int m, input int p, input bit c);
		int d;
		int f;
		d = 10 ** (4 - (p > 4 ? 4 : p));
		f = (v >= 0) ? v / d * d : -((-v + d - 1) / d * d);
		case (m)
			1: return f + ((v - f) * 2 >= d ? d : 0);
			2: return f;
			3: return (f == v) ? f : f + d;
			default: return c ? f : v;
		endcase
	endfunction
	task automatic do_reset();
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		chk("rst_ready", 64'h0, 64'(in_rdy));
		chk("rst_value", 64'h0, 64'(val));
		rst = 1'b0;
		filt = '0;
		pk = '0;
		rnd = '0;
		rst_src = '0;
	endtask
	task automatic proc(input logic signed [31:0] x);
		src.send(x, 4 * SC, ok);
		chk("taken", 64'h1, 64'(ok));
		for (int t = 0; t < 4 * SC && out_v !== 1'b1; t++) begin
			@(posedge clk);
			#1;
		end
		chk("strobe", 64'h1, 64'(strobe));
	endtask
	initial begin
		stall = 1'b0;
		do_reset();
		foreach (vals[i]) begin
			for (int m = 0; m < 4; m++) begin
				for (int p = 0; p < 6; p++) begin
					rnd.mode = chan_proc_pkg::round_mode_t'(m);
					rnd.precision = 3'(p);
					proc(vals[i]);
					e = ref_rnd(vals[i], m, p, 1'b0);
					chk("value", 64'(e), 64'(val));
					chk("disp", 64'(ref_rnd(vals[i], m, p, 1'b1)), 64'(disp));
					chk("bin_on", 64'(e > 0), 64'(bin_on));
				end
			end
		end
		rnd = '0;
		proc(32'sh6d948a22);
		chk("time", 64'({1'b0, 16'h0, 3'h2, 5'h3, 6'h4, 6'h5, 14'h4d2}), 64'(tm));
		proc(-32'sh6d948a22);
		chk("time", 64'({1'b1, 16'h0, 3'h2, 5'h3, 6'h4, 6'h5, 14'h4d2}), 64'(tm));
		do_reset();
		filt = '{chan_proc_pkg::FILT_SMOOTH, 16'h0005, 16'h8000};
		proc(32'sh2710);
		chk("first", 64'h2710, 64'(val));
		proc(32'sh7530);
		chk("smooth", 64'h4e20, 64'(val));
		proc(32'sh0);
		chk("smooth", 64'h2710, 64'(val));
		filt.decay_const = 16'h0;
		proc(32'shc350);
		chk("no_tc", 64'hc350, 64'(val));
		do_reset();
		filt.mode = chan_proc_pkg::FILT_PEAK;
		pk = '{chan_proc_pkg::DIR_PEAKS, 32'h2710, 16'h0064, 1'b0};
		rst_src = 32'sh1;
		proc(32'sh2710);
		proc(32'shc350);
		proc(32'shafc8);
		chk("below_thr", 64'h0, 64'(held));
		proc(32'sh9c40);
		chk("peak", 64'hc350, 64'(val));
		proc(32'sh4e20);
		chk("src_off", 64'hc350, 64'(val));
		proc(32'sh15f90);
		proc(32'sh11170);
		chk("new_peak", 64'h15f90, 64'(val));
		pk.rst_en = 1'b1;
		proc(32'shfde8);
		chk("ext_rst", 64'hfde8, 64'(val));
		pk.rst_en = 1'b0;
		pk.hold_samples = 16'h1;
		rst_src = 32'sh0;
		proc(32'sh13880);
		proc(32'shea60);
		repeat (3) proc(32'shea60);
		chk("expired", 64'hea60, 64'(val));
		chk("expired", 64'h0, 64'(held));
		do_reset();
		filt.mode = chan_proc_pkg::FILT_PEAK;
		pk = '{chan_proc_pkg::DIR_VALLEYS, 32'h2710, 16'h0064, 1'b0};
		proc(32'sh0);
		proc(-32'shc350);
		proc(-32'sh9c40);
		chk("valley", -64'shc350, 64'(val));
		do_reset();
		stall = 1'b1;
		src.got.delete();
		ok = 1'b1;
		while (ok && n < 12) begin
			src.send(32'(n + 1), 3 * SC, ok);
			if (ok)
				n++;
		end
		chk("fill", 64'h1, 64'(n == 8 || n == 9));
		chk("full", 64'h0, 64'(in_rdy));
		stall = 1'b0;
		for (int t = 0; t < 16 * SC && src.got.size() < n; t++) begin
			@(posedge clk);
			#1;
		end
		foreach (src.got[j]) chk("order", 64'(j + 1), 64'(src.got[j]));
		chk("count", 64'(n), 64'(src.got.size()));
		report_and_stop();
	end
endmodule // channel_smooth_peak_round_bench

/* sample_fifo.sv */
`timescale 1ns/10ps
module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Fill side
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	// Drain side
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic full_q, full_d, empty_q, empty_d;
	logic push, pop;

	assign push = i_valid && !full_q;
	assign pop = i_ready && !empty_q;
	assign o_ready = !full_q;
	assign o_valid = !empty_q;
	assign o_data = mem[rd_q];

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
		full_d = (cnt_d == CW'(DEPTH));
		empty_d = (cnt_d == '0);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			full_q <= full_d;
			empty_q <= empty_d;
		end
	end

	// Storage has no reset; empty_q guards the read side
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem[wr_q] <= i_data;
		end
	end
endmodule // sample_fifo

/* value_rounder.sv */
`timescale 1ns/10ps
module value_rounder (
	// Value in
	input wire logic signed [chan_proc_pkg::DATA_W-1:0] i_value,
	input wire chan_proc_pkg::round_cfg_t i_cfg,
	// Rounded and display values
	output logic signed [chan_proc_pkg::DATA_W-1:0] o_value,
	output logic signed [chan_proc_pkg::DATA_W-1:0] o_disp
);
	logic signed [chan_proc_pkg::DATA_W:0] div, quo, rem, flo, res, up;
	logic [chan_proc_pkg::PREC_W-1:0] prec;

	always_comb begin
		prec = (i_cfg.precision > chan_proc_pkg::PREC_MAX) ? chan_proc_pkg::PREC_MAX : i_cfg.precision;
		unique case (prec)
			3'h0: div = 33'sd10000;
			3'h1: div = 33'sd1000;
			3'h2: div = 33'sd100;
			3'h3: div = 33'sd10;
			default: div = 33'sd1;
		endcase
		quo = 33'(i_value) / div;
		rem = 33'(i_value) - quo * div;
		// Division truncates toward zero; pull negatives down to the floor
		flo = (rem < 0) ? (quo - 33'sd1) * div : quo * div;
		res = 33'(i_value) - flo;
		up = flo + div;
		unique case (i_cfg.mode)
			chan_proc_pkg::RND_STD: o_value = (res * 2 >= div) ? up[31:0] : flo[31:0];
			chan_proc_pkg::RND_FLOOR: o_value = flo[31:0];
			chan_proc_pkg::RND_CEIL: o_value = (res != 0) ? up[31:0] : flo[31:0];
			default: o_value = i_value;
		endcase
		// With rounding off, shown digits are cut to the floor; the stored value keeps full precision
		o_disp = (i_cfg.mode == chan_proc_pkg::RND_OFF) ? flo[31:0] : o_value;
	end
endmodule // value_rounder
